//--- pkg/io_cmd_pkg.sv
// Purpose: constants for the control line, timer, debounce and sequencer block
// Assumes: 40 MHz clock, word registers on a plain strobe port
// Notes: Functional notes below
// Functional notes
// - line direction read returns 0 for input, 1 for output of selected line
// - line source codes 0,4,6,10,18,30 choose the selected line driver
// - line inversion 0 passes, 1 inverts the line output
// - user output level 0 low, 1 high, drives line when chosen
// - timer trigger source codes 0,4,6,22,30; 0 disables triggering
// - timer output stays active for duration 1 to 60,000,000 microseconds
// - after trigger, wait delay 0 to 60,000,000 microseconds before active
// - trigger activation 0 falling, 1 rising, 2 low level, 3 high level
// - timer reset clears progress, restarts timer, then acknowledges
// - timer status reads 0 idle, 1 waiting, 2 active
// - input line debounce interval 0 to 1,000,000 microseconds, readable
// - sequencer mode 0 disables, 1 enables sequencing
// - sequencer configuration mode entered by 1, left by 0, readable
// - sequencer set selector holds index 0 to 31
// - sequencer set count holds 1 to 32, readable
// - active sequencer set index 0 to 31 is readable
// - sequencer reset makes set 0 active
// - line selector 0 or 1 picks the line for direction, source, inversion
package io_cmd_pkg;
    // timing
    localparam int CLK_NS = 25;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_NS;
    // register byte addresses
    localparam logic [7:0] A_LINE_SEL = 8'h00;
    localparam logic [7:0] A_LINE_DIR = 8'h04;
    localparam logic [7:0] A_LINE_SRC = 8'h08;
    localparam logic [7:0] A_LINE_INV = 8'h0c;
    localparam logic [7:0] A_USER_OUT = 8'h10;
    localparam logic [7:0] A_TMR_SRC = 8'h14;
    localparam logic [7:0] A_TMR_DUR = 8'h18;
    localparam logic [7:0] A_TMR_DLY = 8'h1c;
    localparam logic [7:0] A_TMR_ACT = 8'h20;
    localparam logic [7:0] A_TMR_RST = 8'h24;
    localparam logic [7:0] A_TMR_STAT = 8'h28;
    localparam logic [7:0] A_DBT = 8'h2c;
    localparam logic [7:0] A_SEQ_MODE = 8'h30;
    localparam logic [7:0] A_SEQ_CFG = 8'h34;
    localparam logic [7:0] A_SEQ_SEL = 8'h38;
    localparam logic [7:0] A_SEQ_CNT = 8'h3c;
    localparam logic [7:0] A_SEQ_ACT = 8'h40;
    localparam logic [7:0] A_SEQ_RST = 8'h44;
    // signal source codes
    localparam logic [4:0] SRC_OFF = 5'h00;
    localparam logic [4:0] SRC_FRAME = 5'h04;
    localparam logic [4:0] SRC_EXPO = 5'h06;
    localparam logic [4:0] SRC_USER = 5'h0a;
    localparam logic [4:0] SRC_TIMER = 5'h12;
    localparam logic [4:0] SRC_FIRST_INPUT_LINE = 5'h16;
    localparam logic [4:0] SRC_STROBE = 5'h1e;
    // activation codes
    localparam logic [1:0] ACT_FALL = 2'h0;
    localparam logic [1:0] ACT_RISE = 2'h1;
    localparam logic [1:0] ACT_LOW = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;
    // limits and reset values
    localparam logic [25:0] TIME_MAX = 26'h3938700;
    localparam logic [19:0] DBT_MAX = 20'hf4240;
    localparam logic [25:0] DUR_RST = 26'h0000001;
    localparam logic [5:0] SEQ_CNT_MAX = 6'h20;
    localparam logic [5:0] SEQ_CNT_RST = 6'h01;
    localparam logic [1:0] LINE_DIR = 2'h2;
    // timer status, gray along idle-wait-delay-active
    typedef enum logic [1:0] {
        TS_IDLE = 2'h0,
        TS_WAIT = 2'h1,
        TS_DELAY = 2'h3,
        TS_ACTIVE = 2'h2
    } tmr_state_e;
endpackage

//--- rtl/io_debounce.sv
// Purpose: synchronise and debounce the input line
// Assumes: us_tick is a one-cycle pulse each microsecond
// Notes: interval 0 passes the synchronised level straight through
`timescale 1ns/1ps
module io_debounce (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line and control
    input wire logic pin,
    input wire logic us_tick,
    input wire logic [19:0] interval,
    // filtered level
    output logic level_q
);
    logic s1_q, s2_q, level_d;
    logic [19:0] cnt_q, cnt_d;

    // next level: a new value must hold for the whole interval
    always_comb begin
        level_d = level_q;
        cnt_d = cnt_q;
        if (s2_q == level_q) begin
            cnt_d = 20'h0;
        end else if (interval == 20'h0) begin
            level_d = s2_q;
        end else if (us_tick) begin
            if (cnt_q + 20'h1 >= interval) begin
                level_d = s2_q;
                cnt_d = 20'h0;
            end else begin
                cnt_d = cnt_q + 20'h1;
            end
        end
    end

    // two-flop synchroniser and filter state
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            level_q <= 1'b0;
            cnt_q <= 20'h0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            level_q <= level_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

//--- rtl/io_cmd_core.sv
// Purpose: command registers for control lines, timer, debounce and sequencer
// Assumes: one command at a time; reads answer the next cycle
// Notes: line 0 is input, line 1 output; ack or nak pulses after each write, nak only after a bad read
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module io_cmd_core
    import io_cmd_pkg::*;
#(
    parameter int US_CYC = CYC_PER_US
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_q,
    output logic ack_q,
    output logic nak_q,
    // camera signals
    input wire logic frame_active,
    input wire logic exposure_active,
    input wire logic strobe,
    input wire logic first_input_line_pin,
    input wire logic seq_step,
    // outputs
    output logic [1:0] line_out_q,
    output logic [1:0] line_oe_q,
    output logic timer_out_q,
    output logic [4:0] seq_act_q,
    output logic seq_mode_q,
    output logic seq_cfg_q
);
    if (US_CYC < 1 || US_CYC > 63) begin : g_bad_div
        $error("US_CYC out of range");
    end

    // pick a source signal by its code; sig = {strobe,first_input_line,timer,user,expo,frame}
    function automatic logic pick(input logic [4:0] code, input logic [5:0] sig);
        unique case (code)
            SRC_FRAME: pick = sig[0];
            SRC_EXPO: pick = sig[1];
            SRC_USER: pick = sig[2];
            SRC_TIMER: pick = sig[3];
            SRC_FIRST_INPUT_LINE: pick = sig[4];
            SRC_STROBE: pick = sig[5];
            default: pick = 1'b0;
        endcase
    endfunction

    // is a 0/1 value
    function automatic logic is_bit(input logic [31:0] v);
        is_bit = (v[31:1] == 31'h0);
    endfunction

    logic line_sel_q, line_sel_d, user_out_q, user_out_d, seq_mode_d, seq_cfg_d;
    logic [1:0] line_inv_q, line_inv_d, tact_q, tact_d;
    logic [4:0] line_src_q [2];
    logic [4:0] line_src_d [2];
    logic [4:0] tsrc_q, tsrc_d, seq_sel_q, seq_sel_d, seq_act_d;
    logic [25:0] tdur_q, tdur_d, tdly_q, tdly_d;
    logic [19:0] dbt_q, dbt_d;
    logic [5:0] seq_cnt_q, seq_cnt_d;
    logic ok, bad, tmr_restart, seq_rst;
    logic [31:0] rdata_d;
    logic first_input_line_f, trig_sig, trig_prev_q, trig_hit;
    logic [5:0] sig;
    logic [5:0] fdiv_q, fdiv_d, pre_q, pre_d;
    logic us_free, us_tick;
    logic [25:0] cnt_q, cnt_d;
    tmr_state_e tst_q, tst_d;
    logic [1:0] line_out_d, line_oe_d;

    // command decode and settings, with range checks
    always_comb begin
        line_sel_d = line_sel_q;
        line_src_d = line_src_q;
        line_inv_d = line_inv_q;
        user_out_d = user_out_q;
        tsrc_d = tsrc_q;
        tdur_d = tdur_q;
        tdly_d = tdly_q;
        tact_d = tact_q;
        dbt_d = dbt_q;
        seq_mode_d = seq_mode_q;
        seq_cfg_d = seq_cfg_q;
        seq_sel_d = seq_sel_q;
        seq_cnt_d = seq_cnt_q;
        ok = 1'b0;
        tmr_restart = 1'b0;
        seq_rst = 1'b0;
        if (wr) begin
            unique case (addr)
                A_LINE_SEL: ok = is_bit(wdata);
                A_LINE_SRC: ok = (wdata[31:5] == 27'h0) &&
                    (wdata[4:0] inside {SRC_OFF, SRC_FRAME, SRC_EXPO,
                     SRC_USER, SRC_TIMER, SRC_STROBE});
                A_LINE_INV: ok = is_bit(wdata);
                A_USER_OUT: ok = is_bit(wdata);
                A_TMR_SRC: ok = (wdata[31:5] == 27'h0) &&
                    (wdata[4:0] inside {SRC_OFF, SRC_FRAME, SRC_EXPO,
                     SRC_FIRST_INPUT_LINE, SRC_STROBE});
                A_TMR_DUR: ok = (wdata != 32'h0) &&
                    (wdata <= {6'h0, TIME_MAX});
                A_TMR_DLY: ok = (wdata <= {6'h0, TIME_MAX});
                A_TMR_ACT: ok = (wdata[31:2] == 30'h0);
                A_TMR_RST: ok = 1'b1;
                A_DBT: ok = (wdata <= {12'h0, DBT_MAX});
                A_SEQ_MODE: ok = is_bit(wdata);
                A_SEQ_CFG: ok = is_bit(wdata);
                A_SEQ_SEL: ok = (wdata[31:5] == 27'h0);
                A_SEQ_CNT: ok = (wdata != 32'h0) &&
                    (wdata <= {26'h0, SEQ_CNT_MAX});
                A_SEQ_RST: ok = 1'b1;
                default: ok = 1'b0;
            endcase
            if (ok) begin
                unique case (addr)
                    A_LINE_SEL: line_sel_d = wdata[0];
                    A_LINE_SRC: line_src_d[line_sel_q] = wdata[4:0];
                    A_LINE_INV: line_inv_d[line_sel_q] = wdata[0];
                    A_USER_OUT: user_out_d = wdata[0];
                    A_TMR_SRC: tsrc_d = wdata[4:0];
                    A_TMR_DUR: tdur_d = wdata[25:0];
                    A_TMR_DLY: tdly_d = wdata[25:0];
                    A_TMR_ACT: tact_d = wdata[1:0];
                    A_TMR_RST: tmr_restart = 1'b1;
                    A_DBT: dbt_d = wdata[19:0];
                    A_SEQ_MODE: seq_mode_d = wdata[0];
                    A_SEQ_CFG: seq_cfg_d = wdata[0];
                    A_SEQ_SEL: seq_sel_d = wdata[4:0];
                    A_SEQ_CNT: seq_cnt_d = wdata[5:0];
                    default: seq_rst = 1'b1;
                endcase
            end
        end
    end

    // read mux; unmapped and write-only addresses read zero and nak
    always_comb begin
        rdata_d = 32'h0;
        bad = wr && !ok;
        if (rd) begin
            unique case (addr)
                A_LINE_SEL: rdata_d = {31'h0, line_sel_q};
                A_LINE_DIR: rdata_d = {31'h0, LINE_DIR[line_sel_q]};
                A_LINE_SRC: rdata_d = {27'h0, line_src_q[line_sel_q]};
                A_LINE_INV: rdata_d = {31'h0, line_inv_q[line_sel_q]};
                A_USER_OUT: rdata_d = {31'h0, user_out_q};
                A_TMR_SRC: rdata_d = {27'h0, tsrc_q};
                A_TMR_DUR: rdata_d = {6'h0, tdur_q};
                A_TMR_DLY: rdata_d = {6'h0, tdly_q};
                A_TMR_ACT: rdata_d = {30'h0, tact_q};
                A_TMR_STAT: rdata_d = (tst_q == TS_IDLE) ? 32'h0 :
                    (tst_q == TS_ACTIVE) ? 32'h2 : 32'h1;
                A_DBT: rdata_d = {12'h0, dbt_q};
                A_SEQ_MODE: rdata_d = {31'h0, seq_mode_q};
                A_SEQ_CFG: rdata_d = {31'h0, seq_cfg_q};
                A_SEQ_SEL: rdata_d = {27'h0, seq_sel_q};
                A_SEQ_CNT: rdata_d = {26'h0, seq_cnt_q};
                A_SEQ_ACT: rdata_d = {27'h0, seq_act_q};
                default: bad = 1'b1;
            endcase
        end
    end

    // settings and answer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            line_sel_q <= 1'b0;
            line_src_q <= '{SRC_OFF, SRC_OFF};
            line_inv_q <= 2'h0;
            user_out_q <= 1'b0;
            tsrc_q <= SRC_OFF;
            tdur_q <= DUR_RST;
            tdly_q <= 26'h0;
            tact_q <= ACT_RISE;
            dbt_q <= 20'h0;
            seq_mode_q <= 1'b0;
            seq_cfg_q <= 1'b0;
            seq_sel_q <= 5'h0;
            seq_cnt_q <= SEQ_CNT_RST;
            rdata_q <= 32'h0;
            ack_q <= 1'b0;
            nak_q <= 1'b0;
        end else begin
            line_sel_q <= line_sel_d;
            line_src_q <= line_src_d;
            line_inv_q <= line_inv_d;
            user_out_q <= user_out_d;
            tsrc_q <= tsrc_d;
            tdur_q <= tdur_d;
            tdly_q <= tdly_d;
            tact_q <= tact_d;
            dbt_q <= dbt_d;
            seq_mode_q <= seq_mode_d;
            seq_cfg_q <= seq_cfg_d;
            seq_sel_q <= seq_sel_d;
            seq_cnt_q <= seq_cnt_d;
            rdata_q <= rdata_d;
            ack_q <= wr && ok;
            nak_q <= bad;
        end
    end

    // free microsecond tick for the debounce filter
    assign fdiv_d = us_free ? 6'h0 : fdiv_q + 6'h1;
    assign us_free = (fdiv_q == 6'(US_CYC - 1));

    io_debounce u_deb (
        .clk(clk),
        .rst(rst),
        .pin(first_input_line_pin),
        .us_tick(us_free),
        .interval(dbt_q),
        .level_q(first_input_line_f)
    );

    assign sig = {strobe, first_input_line_f, timer_out_q, user_out_q, exposure_active, frame_active};
    assign trig_sig = pick(tsrc_q, sig);
    assign us_tick = (pre_q == 6'(US_CYC - 1));

    // timer: trigger qualify, delay, active phase
    always_comb begin
        tst_d = tst_q;
        cnt_d = us_tick ? cnt_q + 26'h1 : cnt_q;
        pre_d = us_tick ? 6'h0 : pre_q + 6'h1;
        unique case (tact_q)
            ACT_FALL: trig_hit = trig_prev_q && !trig_sig;
            ACT_RISE: trig_hit = !trig_prev_q && trig_sig;
            ACT_LOW: trig_hit = !trig_sig;
            ACT_HIGH: trig_hit = trig_sig;
        endcase
        unique case (tst_q)
            TS_IDLE: if (tsrc_q != SRC_OFF) tst_d = TS_WAIT;
            TS_WAIT: begin
                if (trig_hit) begin
                    tst_d = (tdly_q == 26'h0) ? TS_ACTIVE : TS_DELAY;
                end
            end
            TS_DELAY: if (us_tick && cnt_q + 26'h1 >= tdly_q) tst_d = TS_ACTIVE;
            TS_ACTIVE: if (us_tick && cnt_q + 26'h1 >= tdur_q) tst_d = TS_WAIT;
        endcase
        if (tsrc_q == SRC_OFF) begin
            tst_d = TS_IDLE;
        end
        if (tmr_restart) begin
            tst_d = (tsrc_q == SRC_OFF) ? TS_IDLE : TS_WAIT;
        end
        if (tst_d != tst_q || tmr_restart) begin
            cnt_d = 26'h0;
            pre_d = 6'h0;
        end
    end

    // sequencer set stepping with wrap at the set count
    always_comb begin
        seq_act_d = seq_act_q;
        if (seq_rst) begin
            seq_act_d = 5'h0;
        end else if (seq_step && seq_mode_q && !seq_cfg_q) begin
            seq_act_d = ({1'b0, seq_act_q} + 6'h1 >= seq_cnt_q) ? 5'h0 :
                seq_act_q + 5'h1;
        end
    end

    // line drivers: source pick, then inversion, only on output lines
    for (genvar i = 0; i < 2; i++) begin : g_line
        assign line_out_d[i] = (line_src_q[i] != SRC_OFF) &&
            (pick(line_src_q[i], sig) ^ line_inv_q[i]);
        assign line_oe_d[i] = LINE_DIR[i] && (line_src_q[i] != SRC_OFF);
    end

    // timer, sequencer and line registers
    always_ff @(posedge clk) begin
        if (rst) begin
            fdiv_q <= 6'h0;
            pre_q <= 6'h0;
            cnt_q <= 26'h0;
            tst_q <= TS_IDLE;
            trig_prev_q <= 1'b0;
            timer_out_q <= 1'b0;
            seq_act_q <= 5'h0;
            line_out_q <= 2'h0;
            line_oe_q <= 2'h0;
        end else begin
            fdiv_q <= fdiv_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            tst_q <= tst_d;
            trig_prev_q <= trig_sig;
            timer_out_q <= (tst_d == TS_ACTIVE);
            seq_act_q <= seq_act_d;
            line_out_q <= line_out_d & line_oe_d;
            line_oe_q <= line_oe_d;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [31:0] act_len_q;
    always_ff @(posedge clk) begin
        act_len_q <= timer_out_q ? act_len_q + 32'h1 : 32'h0;
    end

    // marks an active period cut short by a restart, a source off or a new duration
    logic cut_q;
    always_ff @(posedge clk) begin
        cut_q <= timer_out_q && (cut_q || tmr_restart || tsrc_q == SRC_OFF ||
            tdur_d != tdur_q);
    end

    line_dir_a: assert property (rd && addr == A_LINE_DIR |=>
        rdata_q == {31'h0, LINE_DIR[$past(line_sel_q)]}) else $error("line dir");
    src_keep_a: assert property (wr && addr == A_LINE_SRC && wdata == 32'h5 |=>
        nak_q && line_src_q[0] == $past(line_src_q[0]) &&
        line_src_q[1] == $past(line_src_q[1])) else $error("bad src kept");
    inv_timer_a: assert property ($past(line_src_q[1] == SRC_TIMER) |->
        line_out_q[1] == $past(timer_out_q ^ line_inv_q[1])) else $error("inversion");
    user_out_a: assert property ($past(line_src_q[1] == SRC_USER) |->
        line_out_q[1] == $past(user_out_q ^ line_inv_q[1])) else $error("user level");
    tsrc_off_a: assert property (tsrc_q == SRC_OFF |=> !timer_out_q ##1 !timer_out_q)
        else $error("timer fired while off");
    dur_len_a: assert property ($fell(timer_out_q) && !cut_q |->
        act_len_q == tdur_q * US_CYC) else $error("duration");
    dly_zero_a: assert property (tst_q == TS_WAIT && trig_hit && tdly_q == 26'h0 &&
        tsrc_q != SRC_OFF && !tmr_restart |=> timer_out_q) else $error("zero delay");
    rise_only_a: assert property (tst_q == TS_WAIT && tact_q == ACT_RISE &&
        !(trig_sig && !trig_prev_q) |=> tst_q inside {TS_WAIT, TS_IDLE})
        else $error("false trigger");
    tmr_reset_a: assert property (tmr_restart |=> cnt_q == 26'h0 && !timer_out_q ##0 ack_q)
        else $error("timer reset");
    stat_rng_a: assert property (rd && addr == A_TMR_STAT |=> rdata_q <= 32'h2)
        else $error("status code");
    seq_rst_a: assert property (seq_rst |=> seq_act_q == 5'h0) else $error("seq reset");
    act_keep_a: assert property (wr && addr == A_TMR_ACT && wdata > 32'h3 |=>
        nak_q && !ack_q && $stable(tact_q)) else $error("activation kept");

    cover property (tst_q == TS_DELAY ##[1:1000] timer_out_q);
    cover property ($fell(timer_out_q));
    cover property (tmr_restart && timer_out_q);
    cover property (seq_act_q != 5'h0 ##1 seq_act_q == 5'h0);
endmodule

//--- verif/host_cmd_model.sv
// Purpose: host side of the command port, one command at a time
// Assumes: each call starts just after a rising edge
// Notes: released lines carry inverted values so stale data never matches
`timescale 1ns/1ps
module host_cmd_model (
    // clock
    input wire logic clk,
    // command port
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [31:0] rdata_q,
    input wire logic ack_q,
    input wire logic nak_q
);
    logic [31:0] got_data;
    logic [1:0] got_resp;
    // quiet bus at time zero
    initial begin
        addr = 8'hff;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // one strobe, take the answer, then wait before the next command
    task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
        got_data = rdata_q;
        got_resp = {ack_q, nak_q};
        @(posedge clk);
    endtask
endmodule

//--- verif/io_line_timer_sequencer_cmds_bench.sv
// Purpose: self-checking bench for the command core
// Assumes: microsecond shortened to 4 cycles
// Notes: a shadow table of settings predicts every settings read
`timescale 1ns/1ps
module io_line_timer_sequencer_cmds_bench;
    import io_cmd_pkg::*;
    localparam int US = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fa = 1'b0;
    logic ea = 1'b0;
    logic stb = 1'b0;
    logic pin = 1'b0;
    logic step = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata_q;
    logic ack_q;
    logic nak_q;
    logic [1:0] line_out_q;
    logic [1:0] line_oe_q;
    logic timer_out_q;
    logic [4:0] seq_act_q;
    logic seq_mode_q;
    logic seq_cfg_q;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    logic sel = 1'b0;
    logic [31:0] sh [int];
    logic [7:0] regs [13] = '{A_LINE_SEL, A_LINE_SRC, A_LINE_INV, A_USER_OUT, A_TMR_SRC,
        A_TMR_DUR, A_TMR_DLY, A_TMR_ACT, A_DBT, A_SEQ_MODE, A_SEQ_CFG, A_SEQ_SEL, A_SEQ_CNT};
    int srcs [6] = '{0, 4, 6, 10, 18, 30};

    io_cmd_core #(.US_CYC(US)) io_cmd_core_i (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .ack_q(ack_q), .nak_q(nak_q),
        .frame_active(fa), .exposure_active(ea), .strobe(stb), .first_input_line_pin(pin),
        .seq_step(step), .line_out_q(line_out_q), .line_oe_q(line_oe_q),
        .timer_out_q(timer_out_q), .seq_act_q(seq_act_q), .seq_mode_q(seq_mode_q),
        .seq_cfg_q(seq_cfg_q));
    host_cmd_model host_cmd_model_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_q(rdata_q), .ack_q(ack_q), .nak_q(nak_q));

    // clock, 25 ns period
    initial begin
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // whether a write value is accepted at an address
    function automatic logic legal(input logic [7:0] a, input logic [31:0] v);
        case (a)
            A_LINE_SEL, A_LINE_INV, A_USER_OUT, A_SEQ_MODE, A_SEQ_CFG: return v < 2;
            A_LINE_SRC: return v inside {0, 4, 6, 10, 18, 30};
            A_TMR_SRC: return v inside {0, 4, 6, 22, 30};
            A_TMR_DUR: return v >= 1 && v <= TIME_MAX;
            A_TMR_DLY: return v <= TIME_MAX;
            A_TMR_ACT: return v < 4;
            A_DBT: return v <= DBT_MAX;
            A_SEQ_SEL: return v < 32;
            A_SEQ_CNT: return v >= 1 && v <= 32;
            A_TMR_RST, A_SEQ_RST: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // per-line settings live under their own key
    function automatic int key(input logic [7:0] a);
        return (a == A_LINE_SRC || a == A_LINE_INV) ? a + 256 * sel : a;
    endfunction

    // expected level of line 1 with the timer idle
    function automatic logic line_exp(input int src, input logic inv, input logic u);
        logic v;
        v = src == 4 ? fa : src == 6 ? ea : src == 10 ? u : src == 30 ? stb : 1'b0;
        return src == 0 ? 1'b0 : v ^ inv;
    endfunction

    task automatic put(input logic [7:0] a, input logic [31:0] v);
        logic ok;
        ok = legal(a, v);
        host_cmd_model_i.cmd(1'b1, a, v);
        check(host_cmd_model_i.got_resp, ok ? 2'b10 : 2'b01);
        if (ok) begin
            sh[key(a)] = v;
        end
        if (ok && a == A_LINE_SEL) begin
            sel = v[0];
        end
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] exp);
        host_cmd_model_i.cmd(1'b0, a, 32'h0);
        check(host_cmd_model_i.got_data, exp);
        check(host_cmd_model_i.got_resp, 2'b00);
    endtask

    task automatic run_timer(input logic p, input logic [1:0] act, input int dly, input int dur,
            input int lo, input int hi);
        int first;
        int len;
        first = -1;
        len = 0;
        put(A_TMR_SRC, p ? 22 : 4);
        put(A_TMR_ACT, act);
        put(A_TMR_DLY, dly);
        put(A_TMR_DUR, dur);
        fa <= ~act[0];
        pin <= ~act[0];
        repeat (40) @(posedge clk);
        put(A_TMR_RST, 32'h0);
        get(A_TMR_STAT, 32'h1);
        if (p) pin <= act[0];
        else fa <= act[0];
        for (int t = 1; t < 600 && (first < 0 || timer_out_q); t++) begin
            @(posedge clk);
            #1;
            if (timer_out_q && first < 0) begin
                first = t;
                fa <= ~act[0];
                pin <= ~act[0];
            end
            len += timer_out_q;
        end
        check(first >= lo + dly * US && first <= hi + dly * US, 1'b1);
        check(len, dur * US);
    endtask

    // main sequence
    initial begin
        logic [7:0] a;
        logic [31:0] v;
        logic hit;
        int e;
        void'($urandom(32'h13bf));
        foreach (regs[i]) sh[regs[i]] = 0;
        sh[A_LINE_SRC + 256] = 0;
        sh[A_LINE_INV + 256] = 0;
        sh[A_TMR_DUR] = 1;
        sh[A_TMR_ACT] = 1;
        sh[A_SEQ_CNT] = 1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (regs[i]) get(regs[i], sh[key(regs[i])]);
        get(A_TMR_STAT, 32'h0);
        put(A_TMR_DUR, TIME_MAX + 1);
        put(A_TMR_DLY, TIME_MAX + 1);
        put(A_DBT, DBT_MAX + 1);
        put(A_LINE_DIR, 32'h0);
        put(8'h48, 32'h0);
        put(A_LINE_SRC, 32'h5);
        host_cmd_model_i.cmd(1'b0, 8'h48, 32'h0);
        check(host_cmd_model_i.got_data, 32'h0);
        check(host_cmd_model_i.got_resp, 2'b01);
        repeat (200) begin
            a = regs[$urandom_range(0, 12)];
            v = $urandom_range(0, 3) == 0 ? $urandom : $urandom_range(0, 40);
            {fa, ea, stb} <= 3'($urandom);
            put(a, v);
            get(a, sh[key(a)]);
            get(A_LINE_DIR, {31'h0, sel});
        end
        put(A_TMR_SRC, 32'h0);
        put(A_LINE_SEL, 32'h1);
        get(A_LINE_DIR, 32'h1);
        foreach (srcs[i]) begin
            for (int k = 0; k < 4; k++) begin
                put(A_LINE_SRC, srcs[i]);
                put(A_LINE_INV, k / 2);
                put(A_USER_OUT, $urandom_range(0, 1));
                {fa, ea, stb} <= 3'($urandom);
                repeat (2) @(posedge clk);
                #1;
                check(line_out_q[1], line_exp(srcs[i], k / 2, sh[A_USER_OUT][0]));
                check(line_oe_q, {srcs[i] != 0, 1'b0});
                check(line_out_q[0], 1'b0);
            end
        end
        for (int k = 0; k < 4; k++) run_timer(1'b0, k, k, k + 1, 1, 3);
        put(A_DBT, 32'h5);
        run_timer(1'b1, ACT_RISE, 0, 1, 4 * US, 6 * US + 4);
        // let the filtered level settle low before the short glitch
        repeat (40) @(posedge clk);
        pin <= 1'b1;
        repeat (2 * US) @(posedge clk);
        pin <= 1'b0;
        hit = 1'b0;
        repeat (60) begin
            @(posedge clk);
            #1;
            hit |= timer_out_q;
        end
        check(hit, 1'b0);
        put(A_TMR_SRC, 32'h4);
        put(A_TMR_DUR, 32'd50);
        put(A_TMR_DLY, 32'h0);
        fa <= 1'b1;
        repeat (6) @(posedge clk);
        get(A_TMR_STAT, 32'h2);
        put(A_TMR_RST, 32'h0);
        #1;
        check(timer_out_q, 1'b0);
        get(A_TMR_STAT, 32'h1);
        put(A_TMR_SRC, 32'h0);
        get(A_TMR_STAT, 32'h0);
        put(A_SEQ_CNT, 32'h3);
        put(A_SEQ_RST, 32'h0);
        e = 0;
        for (int i = 0; i < 24; i++) begin
            put(A_SEQ_MODE, i % 8 != 7);
            put(A_SEQ_CFG, i % 8 == 5);
            check({seq_mode_q, seq_cfg_q}, {i % 8 != 7, i % 8 == 5});
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            if (i % 8 != 7 && i % 8 != 5) e = e + 1 >= 3 ? 0 : e + 1;
            get(A_SEQ_ACT, e);
            check(seq_act_q, e);
            if (i == 10) begin
                put(A_SEQ_RST, 32'h0);
                e = 0;
            end
        end
        tally_and_finish();
    end
endmodule
